// ### rtl/tccu_top.sv
// Capture/compare unit with its 16-bit timer, reached over AXI4-Lite.
// Assumes a single clock; the pin and the external timer clock come from
// outside and are synchronised here; timer prescale is out of scope.
`timescale 1ns/10ps

module tccu_top #(
   parameter int INSTR_DIV = 4
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        capcmp_pin_in,
   output logic             capcmp_pin_out,
   output logic             capcmp_pin_oe,
   input  wire logic        timer_ext_clk_in,
   input  wire logic        sleep_req,
   output logic             special_event,
   output logic             adc_go
);

   initial begin
      if (INSTR_DIV < 2 || INSTR_DIV > 256) begin
         $error("INSTR_DIV out of range");
      end
   end

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   logic [2:0] pin_sync_q,  pin_sync_d;
   logic [2:0] ext_sync_q,  ext_sync_d;
   logic [2:0] slp_sync_q,  slp_sync_d;
   logic       pin_lvl_q,   pin_lvl_d;
   logic       ext_lvl_q,   ext_lvl_d;
   logic       slp_lvl_q,   slp_lvl_d;
   logic       pin_rise,    pin_fall, ext_rise;

   // A change counts once the second and third stages agree.
   always_comb begin
      pin_sync_d = {pin_sync_q[1:0], capcmp_pin_in};
      ext_sync_d = {ext_sync_q[1:0], timer_ext_clk_in};
      slp_sync_d = {slp_sync_q[1:0], sleep_req};
      pin_lvl_d  = pin_lvl_q;
      ext_lvl_d  = ext_lvl_q;
      slp_lvl_d  = slp_lvl_q;
      if (pin_sync_q[1] == pin_sync_q[2]) begin
         pin_lvl_d = pin_sync_q[2];
      end
      if (ext_sync_q[1] == ext_sync_q[2]) begin
         ext_lvl_d = ext_sync_q[2];
      end
      if (slp_sync_q[1] == slp_sync_q[2]) begin
         slp_lvl_d = slp_sync_q[2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_sync_q <= 3'h0;
         ext_sync_q <= 3'h0;
         slp_sync_q <= 3'h0;
         pin_lvl_q  <= 1'b0;
         ext_lvl_q  <= 1'b0;
         slp_lvl_q  <= 1'b0;
      end else begin
         pin_sync_q <= pin_sync_d;
         ext_sync_q <= ext_sync_d;
         slp_sync_q <= slp_sync_d;
         pin_lvl_q  <= pin_lvl_d;
         ext_lvl_q  <= ext_lvl_d;
         slp_lvl_q  <= slp_lvl_d;
      end
   end

   assign pin_rise = pin_lvl_d & ~pin_lvl_q;
   assign pin_fall = ~pin_lvl_d & pin_lvl_q;
   assign ext_rise = ext_lvl_d & ~ext_lvl_q;

   // ----------------------------------------------------------------------
   // Registers and bus slave
   // ----------------------------------------------------------------------
   logic [7:0]  ctrl_q,    ctrl_d;
   logic [15:0] value_q,   value_d;
   logic [15:0] timer_q,   timer_d;
   logic        ext_sel_q, ext_sel_d;
   logic        adc_en_q,  adc_en_d;
   logic        flag_q,    flag_d;
   logic        bvalid_q,  bvalid_d;
   logic        rvalid_q,  rvalid_d;
   logic [31:0] rdata_q,   rdata_d;
   logic [1:0]  bresp_q,   bresp_d;
   logic [1:0]  rresp_q,   rresp_d;
   logic        wr_fire,   rd_fire;
   logic        aw_rdy_q,  aw_rdy_d;
   logic        ar_rdy_q,  ar_rdy_d;
   logic        flag_clr;
   logic        capture,   match_evt;
   logic [3:0]  mode;

   assign mode    = ctrl_q[tccu_pkg::MODE_LSB +: tccu_pkg::MODE_W];
   // Ready is registered; a transfer is taken on the edge that sees it high.
   assign wr_fire = s_axi_awvalid & s_axi_wvalid & aw_rdy_q;
   assign rd_fire = s_axi_arvalid & ar_rdy_q;

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a == tccu_pkg::OFF_CONTROL)
                || (a == tccu_pkg::OFF_VALUE_LOW)
                || (a == tccu_pkg::OFF_VALUE_HIGH)
                || (a == tccu_pkg::OFF_STATUS)
                || (a == tccu_pkg::OFF_TIMER);
   endfunction

   // Timer-tick, special-event and mode-decode signals used by the timer, prescaler and compare logic.
   logic        tick;
   logic        sev_q, sev_d;
   logic        in_capture, in_compare;

   assign in_capture = (mode[3:2] == 2'b01);
   assign in_compare = (mode == tccu_pkg::MODE_TOGGLE) || (mode[3:2] == 2'b10);

   always_comb begin
      ctrl_d    = ctrl_q;
      value_d   = value_q;
      ext_sel_d = ext_sel_q;
      adc_en_d  = adc_en_q;
      flag_clr  = 1'b0;
      bvalid_d  = bvalid_q & ~s_axi_bready;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q & ~s_axi_rready;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      aw_rdy_d  = s_axi_awvalid & s_axi_wvalid & ~bvalid_q & ~aw_rdy_q;
      ar_rdy_d  = s_axi_arvalid & ~rvalid_q & ~ar_rdy_q;
      if (wr_fire) begin
         bvalid_d = 1'b1;
         bresp_d  = known_addr(s_axi_awaddr) ? tccu_pkg::RESP_OKAY
                                             : tccu_pkg::RESP_SLVERR;
         if (s_axi_wstrb[0]) begin
            unique case (s_axi_awaddr)
               tccu_pkg::OFF_CONTROL:    ctrl_d = {2'b00, s_axi_wdata[5:0]};
               tccu_pkg::OFF_VALUE_LOW:  value_d[7:0]  = s_axi_wdata[7:0];
               tccu_pkg::OFF_VALUE_HIGH: value_d[15:8] = s_axi_wdata[7:0];
               tccu_pkg::OFF_STATUS: begin
                  // Writing zero to the flag bit clears it.
                  flag_clr  = ~s_axi_wdata[tccu_pkg::STAT_FLAG];
                  adc_en_d  = s_axi_wdata[tccu_pkg::STAT_ADC_EN];
                  ext_sel_d = s_axi_wdata[tccu_pkg::STAT_EXTCLK];
               end
               default: ;
            endcase
         end
      end
      if (capture) begin
         value_d = timer_q;
      end
      if (rd_fire) begin
         rvalid_d = 1'b1;
         rresp_d  = known_addr(s_axi_araddr) ? tccu_pkg::RESP_OKAY
                                             : tccu_pkg::RESP_SLVERR;
         unique case (s_axi_araddr)
            tccu_pkg::OFF_CONTROL:    rdata_d = {24'h000000, ctrl_q};
            tccu_pkg::OFF_VALUE_LOW:  rdata_d = {24'h000000, value_q[7:0]};
            tccu_pkg::OFF_VALUE_HIGH: rdata_d = {24'h000000, value_q[15:8]};
            tccu_pkg::OFF_STATUS:     rdata_d = {27'h0000000, ext_sel_q,
                                                 slp_lvl_q, adc_en_q,
                                                 capcmp_pin_out, flag_q};
            tccu_pkg::OFF_TIMER:      rdata_d = {16'h0000, timer_q};
            default:                  rdata_d = 32'h00000000;
         endcase
      end
   end

   // Hardware set wins over a software clear in the same cycle.
   assign flag_d = capture | match_evt | (flag_q & ~flag_clr);

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q    <= tccu_pkg::CONTROL_RST;
         value_q   <= {tccu_pkg::VALUE_RST, tccu_pkg::VALUE_RST};
         ext_sel_q <= 1'b0;
         adc_en_q  <= 1'b0;
         flag_q    <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= tccu_pkg::RESP_OKAY;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= tccu_pkg::RESP_OKAY;
         aw_rdy_q  <= 1'b0;
         ar_rdy_q  <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         value_q   <= value_d;
         ext_sel_q <= ext_sel_d;
         adc_en_q  <= adc_en_d;
         flag_q    <= flag_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         aw_rdy_q  <= aw_rdy_d;
         ar_rdy_q  <= ar_rdy_d;
      end
   end

   assign s_axi_awready = aw_rdy_q;
   assign s_axi_wready  = aw_rdy_q;
   assign s_axi_arready = ar_rdy_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // ----------------------------------------------------------------------
   // Timer
   // ----------------------------------------------------------------------
   logic [7:0] div_q, div_d;

   always_comb begin
      div_d = div_q;
      tick  = 1'b0;
      if (ext_sel_q) begin
         tick = ext_rise;
      end else if (!slp_lvl_q) begin
         if (div_q == 8'(INSTR_DIV - 1)) begin
            div_d = 8'h00;
            tick  = 1'b1;
         end else begin
            div_d = div_q + 8'h01;
         end
      end
      timer_d = timer_q;
      if (tick) begin
         // Reset is taken only if the match still holds at this tick.
         if (sev_q && mode == tccu_pkg::MODE_SPECIAL && value_q == timer_q) begin
            timer_d = tccu_pkg::TIMER_RST;
         end else begin
            timer_d = timer_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_q   <= 8'h00;
         timer_q <= tccu_pkg::TIMER_RST;
      end else begin
         div_q   <= div_d;
         timer_q <= timer_d;
      end
   end

   // ----------------------------------------------------------------------
   // Capture prescaler
   // ----------------------------------------------------------------------
   logic [3:0] presc_q, presc_d;

   always_comb begin
      presc_d = presc_q;
      capture = 1'b0;
      if (!in_capture) begin
         presc_d = tccu_pkg::PRESC_RST;
      end else begin
         unique case (mode[1:0])
            2'b00: capture = pin_fall;
            2'b01: capture = pin_rise;
            2'b10: begin
               if (pin_rise) begin
                  // Count is kept across prescale changes.
                  capture = (presc_q[1:0] == tccu_pkg::PRESC_LAST4[1:0]);
                  presc_d = presc_q + 4'h1;
               end
            end
            2'b11: begin
               if (pin_rise) begin
                  capture = (presc_q == tccu_pkg::PRESC_LAST16);
                  presc_d = presc_q + 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         presc_q <= tccu_pkg::PRESC_RST;
      end else begin
         presc_q <= presc_d;
      end
   end

   // ----------------------------------------------------------------------
   // Compare and output
   // ----------------------------------------------------------------------
   logic equal_q, equal_d;
   logic out_q,   out_d;
   logic oe_q,    oe_d;
   logic go_q,    go_d;

   always_comb begin
      equal_d   = in_compare && (value_q == timer_q);
      match_evt = equal_d & ~equal_q;
      out_d     = out_q;
      oe_d      = 1'b0;
      sev_d     = 1'b0;
      go_d      = 1'b0;
      if (mode == tccu_pkg::MODE_OFF) begin
         out_d = 1'b0;
      end
      unique case (mode)
         tccu_pkg::MODE_TOGGLE: begin
            oe_d = 1'b1;
            if (match_evt) out_d = ~out_q;
         end
         tccu_pkg::MODE_SET: begin
            oe_d = 1'b1;
            if (match_evt) out_d = 1'b1;
         end
         tccu_pkg::MODE_CLEAR: begin
            oe_d = 1'b1;
            if (match_evt) out_d = 1'b0;
         end
         tccu_pkg::MODE_SWINT: oe_d = 1'b0;
         tccu_pkg::MODE_SPECIAL: begin
            sev_d = equal_d;
            go_d  = match_evt & adc_en_q;
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         equal_q <= 1'b0;
         out_q   <= 1'b0;
         oe_q    <= 1'b0;
         sev_q   <= 1'b0;
         go_q    <= 1'b0;
      end else begin
         equal_q <= equal_d;
         out_q   <= out_d;
         oe_q    <= oe_d;
         sev_q   <= sev_d;
         go_q    <= go_d;
      end
   end

   assign capcmp_pin_out = out_q;
   assign capcmp_pin_oe  = oe_q;
   assign special_event  = sev_q;
   assign adc_go         = go_q;

endmodule

// ### rtl/tccu_pkg.sv
// Constants shared by the capture/compare unit: register map, field layout,
// mode encodings and reset values.
// Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
package tccu_pkg;
   // ----------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFF_CONTROL    = 8'h00;
   localparam logic [7:0] OFF_VALUE_LOW  = 8'h04;
   localparam logic [7:0] OFF_VALUE_HIGH = 8'h08;
   localparam logic [7:0] OFF_STATUS     = 8'h0C;
   localparam logic [7:0] OFF_TIMER      = 8'h10;
   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int MODE_LSB     = 0;
   localparam int MODE_W       = 4;
   localparam int DUTY_LSB     = 4;
   localparam int DUTY_W       = 2;
   localparam int STAT_FLAG    = 0;
   localparam int STAT_PIN     = 1;
   localparam int STAT_ADC_EN  = 2;
   localparam int STAT_SLEEP   = 3;
   localparam int STAT_EXTCLK  = 4;
   // ----------------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------------
   localparam logic [3:0] MODE_OFF      = 4'h0;
   localparam logic [3:0] MODE_TOGGLE   = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_R4   = 4'h6;
   localparam logic [3:0] MODE_CAP_R16  = 4'h7;
   localparam logic [3:0] MODE_SET      = 4'h8;
   localparam logic [3:0] MODE_CLEAR    = 4'h9;
   localparam logic [3:0] MODE_SWINT    = 4'hA;
   localparam logic [3:0] MODE_SPECIAL  = 4'hB;
   // ----------------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------------
   localparam logic [7:0]  CONTROL_RST = 8'h00;
   localparam logic [7:0]  VALUE_RST   = 8'h00;
   localparam logic [15:0] TIMER_RST   = 16'h0000;
   localparam logic [3:0]  PRESC_RST   = 4'h0;
   localparam logic [3:0]  PRESC_LAST4  = 4'h3;
   localparam logic [3:0]  PRESC_LAST16 = 4'hF;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ### bench/tccu_props.sv
// Assertions for the capture/compare unit, bound to its top-level ports.
// Assumes the mode changes only through AXI4-Lite writes to the control word.
`timescale 1ns/10ps
module tccu_checker #(
   parameter int INSTR_DIV = 4
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        capcmp_pin_out,
   input wire logic        capcmp_pin_oe,
   input wire logic        special_event,
   input wire logic        adc_go
);
   localparam int SE_MAX = 2 * INSTR_DIV;
   logic [3:0] mode_q;
   logic [3:0] mode_d;
   logic       ctl_wr;

   // Shadow of the mode field, taken on the edge that accepts the write.
   always_comb begin
      ctl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
               && s_axi_awaddr == tccu_pkg::OFF_CONTROL && s_axi_wstrb[0];
      mode_d = ctl_wr ? s_axi_wdata[3:0] : mode_q;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= 4'h0;
      end else begin
         mode_q <= mode_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_adc_mode;
      adc_go |-> mode_q == tccu_pkg::MODE_SPECIAL;
   endproperty
   a_adc_mode: assert property (p_adc_mode)
      else $error("adc start outside special event mode");
   property p_adc_once;
      adc_go |=> (!adc_go) [*4];
   endproperty
   a_adc_once: assert property (p_adc_once)
      else $error("adc start repeated within one match");
   property p_se_mode;
      special_event |-> mode_q == tccu_pkg::MODE_SPECIAL
         || $past(mode_q) == tccu_pkg::MODE_SPECIAL;
   endproperty
   a_se_mode: assert property (p_se_mode)
      else $error("special event outside its mode");
   property p_se_ends;
      $rose(special_event) |-> ##[1:SE_MAX] !special_event;
   endproperty
   a_se_ends: assert property (p_se_ends)
      else $error("timer not cleared after special event");
   property p_oe_free;
      (mode_q == tccu_pkg::MODE_SWINT || mode_q == tccu_pkg::MODE_SPECIAL)
         [*3] |-> !capcmp_pin_oe;
   endproperty
   a_oe_free: assert property (p_oe_free)
      else $error("pin driven in a pin-free compare mode");
   property p_off_low;
      (mode_q == tccu_pkg::MODE_OFF) [*3] |-> !capcmp_pin_out && !capcmp_pin_oe;
   endproperty
   a_off_low: assert property (p_off_low)
      else $error("output latch not low while unit is off");
   property p_set_hold;
      (mode_q == tccu_pkg::MODE_SET) [*3] |-> !$fell(capcmp_pin_out);
   endproperty
   a_set_hold: assert property (p_set_hold)
      else $error("output fell in set mode");
   property p_clr_hold;
      (mode_q == tccu_pkg::MODE_CLEAR) [*3] |-> !$rose(capcmp_pin_out);
   endproperty
   a_clr_hold: assert property (p_clr_hold)
      else $error("output rose in clear mode");
   property p_tog_once;
      (mode_q == tccu_pkg::MODE_TOGGLE) [*3] ##0 $changed(capcmp_pin_out)
         |=> $stable(capcmp_pin_out) [*4];
   endproperty
   a_tog_once: assert property (p_tog_once)
      else $error("output toggled twice for one match");
endmodule

bind tccu_top tccu_checker #(.INSTR_DIV(INSTR_DIV)) tccu_checker_inst (
   .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .capcmp_pin_out,
   .capcmp_pin_oe, .special_event, .adc_go);

// ### bench/tccu_far_side.sv
// Far side of the unit: the external pin source and the external timer clock.
// Assumes the bench calls its tasks by hierarchical name.
`timescale 1ns/10ps
module tccu_far_side (
   input  wire logic clk,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      pin_in,
   output logic      ext_clk
);
   logic pin_lvl;

   initial begin
      pin_lvl = 1'b0;
      ext_clk = 1'b0;
   end
   // The wire follows the unit while it drives, else the outside source.
   assign pin_in = pin_oe ? pin_out : pin_lvl;
   task automatic drive(input logic lvl);
      @(posedge clk);
      pin_lvl <= lvl;
      repeat (8) @(posedge clk);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         drive(1'b1);
         drive(1'b0);
      end
   endtask
   // Slow ticks only; the clock stands still between calls.
   task automatic ext_ticks(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk);
         ext_clk <= 1'b1;
         repeat (4) @(posedge clk);
         ext_clk <= 1'b0;
      end
   endtask
endmodule

// ### bench/tccu_top_tb.sv
// Self-checking bench for the capture/compare unit over AXI4-Lite.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tccu_top_tb;
   logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, sleep_req, s_axi_awready;
   logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        capcmp_pin_in, capcmp_pin_out, capcmp_pin_oe, adc_go;
   logic        timer_ext_clk_in, special_event;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   int          fail_count, total_checks, cyc, adc_cnt;

   tccu_top tccu_top_inst (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .capcmp_pin_in, .capcmp_pin_out,
      .capcmp_pin_oe, .timer_ext_clk_in, .sleep_req, .special_event, .adc_go);
   tccu_far_side tccu_far_side_inst (.clk, .pin_out(capcmp_pin_out),
      .pin_oe(capcmp_pin_oe), .pin_in(capcmp_pin_in),
      .ext_clk(timer_ext_clk_in));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (adc_go === 1'b1) adc_cnt <= adc_cnt + 1;
      if (cyc == 60000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge clk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
   endtask
   task automatic rd_pair(output logic [15:0] v);
      rd(tccu_pkg::OFF_VALUE_LOW);
      v[7:0] = rv[7:0];
      rd(tccu_pkg::OFF_VALUE_HIGH);
      v[15:8] = rv[7:0];
   endtask
   // Loads the value pair a short way ahead of the running timer.
   task automatic arm(input logic [3:0] md);
      logic [15:0] t;
      rd(tccu_pkg::OFF_TIMER);
      t = rv[15:0] + 16'd40;
      wr(tccu_pkg::OFF_VALUE_LOW, {24'h0, t[7:0]});
      wr(tccu_pkg::OFF_VALUE_HIGH, {24'h0, t[15:8]});
      wr(tccu_pkg::OFF_CONTROL, {28'h0, md});
      rv = 32'h0;
      for (int n = 0; n < 200 && rv[0] !== 1'b1; n++) begin
         rd(tccu_pkg::OFF_STATUS);
      end
      chk(32'(rv[0]), 32'h1);
      repeat (2) @(posedge clk);
   endtask

   task automatic t_regs();
      rd(tccu_pkg::OFF_CONTROL);
      chk(rv, {24'h0, tccu_pkg::CONTROL_RST});
      wr(tccu_pkg::OFF_VALUE_LOW, 32'h5A);
      wr(tccu_pkg::OFF_VALUE_HIGH, 32'hA5);
      rd(tccu_pkg::OFF_VALUE_LOW);
      chk(rv, 32'h5A);
      rd(tccu_pkg::OFF_VALUE_HIGH);
      chk(rv, 32'hA5);
      rd(8'h14);
      chk({30'h0, rr}, {30'h0, tccu_pkg::RESP_SLVERR});
      chk(rv, 32'h0);
      wr(8'h14, 32'h0);
      chk({30'h0, rr}, {30'h0, tccu_pkg::RESP_SLVERR});
      $display("t_regs done");
   endtask
   task automatic t_cap();
      logic [3:0]  md [4] = '{tccu_pkg::MODE_CAP_FALL, tccu_pkg::MODE_CAP_RISE,
                              tccu_pkg::MODE_CAP_R4, tccu_pkg::MODE_CAP_R16};
      int          nn [4] = '{1, 1, 4, 16};
      logic [15:0] t0;
      logic [15:0] v;
      for (int i = 0; i < 4; i++) begin
         wr(tccu_pkg::OFF_CONTROL, 32'h0);
         wr(tccu_pkg::OFF_CONTROL, {28'h0, md[i]});
         wr(tccu_pkg::OFF_STATUS, 32'h0);
         tccu_far_side_inst.pulse(nn[i] - 1);
         rd(tccu_pkg::OFF_STATUS);
         chk(32'(rv[0]), 32'h0);
         rd(tccu_pkg::OFF_TIMER);
         t0 = rv[15:0];
         tccu_far_side_inst.drive(1'b1);
         rd(tccu_pkg::OFF_STATUS);
         chk(32'(rv[0]), 32'(i != 0));
         tccu_far_side_inst.drive(1'b0);
         rd(tccu_pkg::OFF_STATUS);
         chk(32'(rv[0]), 32'h1);
         rd_pair(v);
         rd(tccu_pkg::OFF_TIMER);
         chk(32'(v > t0 && v < rv[15:0]), 32'h1);
      end
      $display("t_cap done");
   endtask
   task automatic t_cmp();
      logic [3:0] md [4] = '{tccu_pkg::MODE_SET, tccu_pkg::MODE_CLEAR,
                             tccu_pkg::MODE_TOGGLE, tccu_pkg::MODE_SWINT};
      logic       eo [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 4; i++) begin
         wr(tccu_pkg::OFF_STATUS, 32'h0);
         arm(md[i]);
         if (i < 3) chk(32'(capcmp_pin_out), 32'(eo[i]));
         chk(32'(capcmp_pin_oe), 32'(i < 3));
      end
      wr(tccu_pkg::OFF_CONTROL, 32'h0);
      repeat (3) @(posedge clk);
      chk(32'(capcmp_pin_out), 32'h0);
      $display("t_cmp done");
   endtask
   task automatic t_spec();
      int a0;
      for (int en = 1; en >= 0; en--) begin
         wr(tccu_pkg::OFF_STATUS, en != 0 ? 32'h4 : 32'h0);
         a0 = adc_cnt;
         arm(tccu_pkg::MODE_SPECIAL);
         rd(tccu_pkg::OFF_TIMER);
         chk(32'(rv[15:0] < 16'd40), 32'h1);
         chk(32'(adc_cnt - a0), 32'(en));
      end
      wr(tccu_pkg::OFF_CONTROL, 32'h0);
      $display("t_spec done");
   endtask
   task automatic t_sleep();
      logic [15:0] a;
      logic [15:0] v;
      sleep_req <= 1'b1;
      repeat (8) @(posedge clk);
      rd(tccu_pkg::OFF_TIMER);
      a = rv[15:0];
      repeat (40) @(posedge clk);
      rd(tccu_pkg::OFF_TIMER);
      chk({16'h0, rv[15:0]}, {16'h0, a});
      sleep_req <= 1'b0;
      repeat (40) @(posedge clk);
      rd(tccu_pkg::OFF_TIMER);
      chk(32'(rv[15:0] > a), 32'h1);
      wr(tccu_pkg::OFF_CONTROL, {28'h0, tccu_pkg::MODE_CAP_RISE});
      wr(tccu_pkg::OFF_STATUS, 32'h10);
      sleep_req <= 1'b1;
      rd(tccu_pkg::OFF_TIMER);
      a = rv[15:0];
      tccu_far_side_inst.ext_ticks(10);
      rd(tccu_pkg::OFF_TIMER);
      a = rv[15:0] - a;
      chk({16'h0, a}, 32'd10);
      tccu_far_side_inst.pulse(1);
      rd_pair(v);
      rd(tccu_pkg::OFF_TIMER);
      chk({16'h0, v}, {16'h0, rv[15:0]});
      sleep_req <= 1'b0;
      $display("t_sleep done");
   endtask

   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sleep_req} = 4'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      {fail_count, total_checks, cyc, adc_cnt} = 128'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_cap();
      t_cmp();
      t_spec();
      t_sleep();
      print_verdict();
   end
endmodule
